// ### hdl/rfp_cfg.svh
// Purpose: register map, field positions, reset values and timing for the rx pause control
// Assumes: 32-bit apb data, one aligned word per register
// Notes: definitions only
`ifndef RFP_CFG_SVH
`define RFP_CFG_SVH
`define RFP_OFS_START_RETX 12'h04C
`define RFP_OFS_WATERMARK 12'h050
`define RFP_SRTH_LSB 16
`define RFP_RETX_LSB 0
`define RFP_RETX_W 16
`define RFP_HWM_LSB 16
`define RFP_LWM_LSB 0
`define RFP_SRTH_RST 12'hFFF
`define RFP_RETX_RST 16'hFFFF
`define RFP_WM_RST 13'h1FFF
`define RFP_XOFF_VAL 16'hFFFF
`define RFP_XON_VAL 16'h0000
`define RFP_QUANTUM_BITS 7'h40
`define RFP_XING_STAGES 2
`endif

// ### hdl/rfp_pkg.sv
// Purpose: shared types for the rx pause control
// Assumes: rfp_cfg.svh supplies the numbers
// Notes: none
package rfp_pkg;
    // pause request sequencer, gray along idle-xoff-wait-xon
    typedef enum logic [1:0] {
        RFP_IDLE = 2'b00,
        RFP_XOFF = 2'b01,
        RFP_HOLD = 2'b11,
        RFP_XON = 2'b10
    } rfp_state_t;
    // control frame request toward the mac transmit path
    typedef struct packed {
        logic req;
        logic [15:0] pause_val;
    } rfp_ctrl_t;
endpackage

// ### hdl/rfp_rx_fifo_ctrl.sv
// Purpose: rx start threshold, fabric ready gating and xoff/xon pause requests
// Assumes: all inputs synchronous to pclk; bit_tick pulses once per link bit time
// Notes: apb slave answers with no wait state; unmapped addresses give pslverr
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "rfp_cfg.svh"

// How it works
// - ready held low until frame words reach threshold
// - ready also needs accept, plus crossing delay
// - all-ones threshold waits for whole frame
// - after xoff ack, count quanta, then re-request xoff
// - level at high watermark requests xoff frame
// - level down to low watermark requests xon
// - threshold and watermark widths follow receive ram address width; retransmit count is fixed at 16 bits
module rfp_rx_fifo_ctrl
    import rfp_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic frame_start,
    input wire logic frame_word,
    input wire logic frame_end,
    input wire logic fabric_accept,
    input wire logic short_frame_drop_setting,
    input wire logic [ADDR_W:0] rx_level,
    input wire logic bit_tick,
    input wire logic ctrl_ack,
    output logic fabric_rx_ready,
    output logic tx_ctrl_req,
    output logic [15:0] tx_pause_val
);
    localparam int SW = ADDR_W;
    localparam int WW = ADDR_W + 1;

    logic [SW-1:0] srth_q;
    logic [15:0] retx_q;
    logic [WW-1:0] hwm_q, lwm_q;
    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [SW:0] frm_cnt_q;
    logic frm_done_q;
    logic [`RFP_XING_STAGES-1:0] rdy_pipe_q;
    logic [6:0] bit_cnt_q;
    logic quantum_tick;
    logic [15:0] quanta_q;
    rfp_state_t state_q;
    rfp_ctrl_t ctrl_q;
    logic setup, access_wr, hit_a, hit_b, thresh_met;
    logic [31:0] rd_word;

    assign setup = psel & ~penable;
    assign access_wr = psel & penable & pready_q & pwrite & ~pslverr_q;
    assign hit_a = (paddr == `RFP_OFS_START_RETX);
    assign hit_b = (paddr == `RFP_OFS_WATERMARK);

    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_a) begin
            rd_word[`RFP_SRTH_LSB +: SW] = srth_q;
            rd_word[`RFP_RETX_LSB +: `RFP_RETX_W] = retx_q;
        end else if (hit_b) begin
            rd_word[`RFP_HWM_LSB +: WW] = hwm_q;
            rd_word[`RFP_LWM_LSB +: WW] = lwm_q;
        end
    end

    // answer is prepared at setup so the access phase completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~(hit_a | hit_b);
            if (setup) begin
                prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
            end
        end
    end

    // config writes; reserved bits dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            srth_q <= SW'(`RFP_SRTH_RST);
            retx_q <= `RFP_RETX_RST;
            hwm_q <= WW'(`RFP_WM_RST);
            lwm_q <= WW'(`RFP_WM_RST);
        end else if (access_wr) begin
            if (hit_a) begin
                srth_q <= pwdata[`RFP_SRTH_LSB +: SW];
                retx_q <= pwdata[`RFP_RETX_LSB +: `RFP_RETX_W];
            end else if (hit_b) begin
                hwm_q <= pwdata[`RFP_HWM_LSB +: WW];
                lwm_q <= pwdata[`RFP_LWM_LSB +: WW];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frm_cnt_q <= '0;
            frm_done_q <= 1'b0;
        end else if (frame_start) begin
            frm_cnt_q <= (SW+1)'(frame_word);
            // a one-cycle frame ends as it starts: the set wins over the clear
            frm_done_q <= frame_end;
        end else begin
            if (frame_word && !(&frm_cnt_q)) begin
                frm_cnt_q <= frm_cnt_q + (SW+1)'(1);
            end
            if (frame_end) begin
                frm_done_q <= 1'b1;
            end
        end
    end

    // all-ones means store the whole frame first
    // threshold above 18 is software's job; short_frame_drop_setting only advises
    always_comb begin
        if (&srth_q) begin
            thresh_met = frm_done_q;
        end else begin
            thresh_met = (frm_cnt_q >= {1'b0, srth_q}) | frm_done_q;
        end
    end

    // gate with accept, then delay as the clock crossing would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdy_pipe_q <= '0;
        end else begin
            rdy_pipe_q <= {rdy_pipe_q[`RFP_XING_STAGES-2:0], thresh_met & fabric_accept};
        end
    end
    assign fabric_rx_ready = rdy_pipe_q[`RFP_XING_STAGES-1];

    // pause quantum divider: 64 bit times per quantum
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt_q <= 7'h00;
        end else if (bit_tick) begin
            bit_cnt_q <= (bit_cnt_q == `RFP_QUANTUM_BITS - 7'h01) ? 7'h00 : bit_cnt_q + 7'h01;
        end
    end
    assign quantum_tick = bit_tick & (bit_cnt_q == `RFP_QUANTUM_BITS - 7'h01);

    // pause sequencer; leaving hold early means level reached low watermark
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= RFP_IDLE;
            quanta_q <= 16'h0000;
        end else begin
            case (state_q)
                RFP_IDLE: begin
                    if (rx_level >= hwm_q) begin
                        state_q <= RFP_XOFF;
                    end
                end
                RFP_XOFF: begin
                    if (ctrl_ack) begin
                        state_q <= RFP_HOLD;
                        quanta_q <= retx_q;
                    end
                end
                RFP_HOLD: begin
                    if (rx_level <= lwm_q) begin
                        state_q <= RFP_XON;
                    // retransmit time expired while still above low
                    end else if (quanta_q == 16'h0000) begin
                        state_q <= RFP_XOFF;
                    end else if (quantum_tick) begin
                        quanta_q <= quanta_q - 16'h0001;
                    end
                end
                RFP_XON: begin
                    if (ctrl_ack) begin
                        state_q <= RFP_IDLE;
                    end
                end
                default: begin
                    state_q <= RFP_IDLE;
                end
            endcase
        end
    end

    // request outputs registered off the current state view
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= '0;
        end else begin
            ctrl_q.req <= (state_q == RFP_XOFF || state_q == RFP_XON) && !ctrl_ack;
            ctrl_q.pause_val <= (state_q == RFP_XON) ? `RFP_XON_VAL : `RFP_XOFF_VAL;
        end
    end
    assign tx_ctrl_req = ctrl_q.req;
    assign tx_pause_val = ctrl_q.pause_val;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // checks
    ready_needs_accept_a: assert property (@(posedge pclk) disable iff (!presetn)
        fabric_rx_ready |-> $past(fabric_accept, 2))
        else $error("ready without earlier accept");
    ready_thresh_a: assert property (@(posedge pclk) disable iff (!presetn)
        fabric_rx_ready |-> $past(thresh_met, 2))
        else $error("ready before threshold");
    full_frame_a: assert property (@(posedge pclk) disable iff (!presetn)
        (&srth_q) && !frm_done_q && $stable(srth_q) |-> ##2 !fabric_rx_ready)
        else $error("ready before frame stored");
    xoff_on_high_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == RFP_IDLE && rx_level >= hwm_q
        |=> ##1 tx_ctrl_req && tx_pause_val == `RFP_XOFF_VAL)
        else $error("no xoff at high watermark");
    xon_on_low_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == RFP_HOLD && rx_level <= lwm_q
        |=> ##1 tx_ctrl_req && tx_pause_val == `RFP_XON_VAL)
        else $error("no xon at low watermark");
    retx_reload_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == RFP_XOFF && ctrl_ack |=> state_q == RFP_HOLD && quanta_q == $past(retx_q))
        else $error("retransmit count not loaded");
    retx_again_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == RFP_HOLD && quanta_q == 16'h0000 && rx_level > lwm_q
        |=> state_q == RFP_XOFF)
        else $error("xoff not re-requested");
    reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && hit_b |-> prdata[31:29] == 3'h0 && prdata[15:13] == 3'h0)
        else $error("reserved bits not zero");
    apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready)
        else $error("apb access not answered");
    xoff_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == RFP_XOFF ##1 state_q == RFP_HOLD);
    xon_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_q == RFP_XON ##1 state_q == RFP_IDLE);
    ready_cov_c: cover property (@(posedge pclk) disable iff (!presetn)
        !fabric_rx_ready ##1 fabric_rx_ready);
endmodule // rfp_rx_fifo_ctrl

// ### tb/rfp_partner.sv
// Purpose: far-side model, fabric accept and mac control-frame ack
// Assumes: a request stays up until it is acked
// Notes: acks slowly, four cycles after the request is seen
`timescale 1ns/1ns
module rfp_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic accept_en,
    input wire logic tx_ctrl_req,
    output logic fabric_accept,
    output logic ctrl_ack
);
    logic [1:0] dly_q;
    // accept registered, as real fabric logic would drive it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fabric_accept <= 1'b0;
        else fabric_accept <= accept_en;
    end
    // single ack pulse so one request is never acked twice
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_q <= 2'h0;
            ctrl_ack <= 1'b0;
        end else begin
            ctrl_ack <= 1'b0;
            if (!tx_ctrl_req || ctrl_ack) dly_q <= 2'h0;
            else if (dly_q == 2'h3) ctrl_ack <= 1'b1;
            else dly_q <= dly_q + 2'h1;
        end
    end
endmodule // rfp_partner

// ### tb/tb.sv
// Purpose: self-checking bench for rfp_rx_fifo_ctrl
// Assumes: apb slave answers on its own time, partner acks frames
// Notes: bit_tick every other cycle, so one quantum is 128 cycles
`timescale 1ns/1ns
`include "rfp_cfg.svh"
module tb;
    import rfp_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, fabric_rx_ready, tx_ctrl_req, fabric_accept, ctrl_ack, err;
    logic frame_start = 1'b0, frame_word = 1'b0, frame_end = 1'b0, accept_en = 1'b1;
    logic short_frame_drop_setting = 1'b0, bit_tick = 1'b0;
    logic [12:0] rx_level = 13'h0000;
    logic [15:0] tx_pause_val;
    int n_errors = 0, check_count = 0;
    always #5 pclk = ~pclk;
    // one bit time every two cycles
    always @(posedge pclk) bit_tick <= ~bit_tick;
    rfp_rx_fifo_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .frame_start, .frame_word, .frame_end, .fabric_accept,
        .short_frame_drop_setting, .rx_level, .bit_tick, .ctrl_ack, .fabric_rx_ready,
        .tx_ctrl_req, .tx_pause_val);
    rfp_partner far (.pclk, .presetn, .accept_en, .tx_ctrl_req, .fabric_accept, .ctrl_ack);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait-state limit here; the watchdog ends a hung access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge pclk);
        #1;
    endtask
    task automatic wait_req(input logic want);
        for (int n = 0; n < 400 && tx_ctrl_req !== want; n++) tick(1);
    endtask
    task automatic words(input int k);
        repeat (k) begin
            @(posedge pclk);
            frame_word <= 1'b1;
        end
        @(posedge pclk);
        frame_word <= 1'b0;
    endtask
    task automatic mark(input logic is_end);
        @(posedge pclk);
        if (is_end) frame_end <= 1'b1;
        else frame_start <= 1'b1;
        @(posedge pclk);
        frame_end <= 1'b0;
        frame_start <= 1'b0;
    endtask
    task automatic t_regs();
        apb(1'b0, `RFP_OFS_START_RETX, 32'h0);
        chk(rd, {4'h0, `RFP_SRTH_RST, `RFP_RETX_RST});
        apb(1'b0, `RFP_OFS_WATERMARK, 32'h0);
        chk(rd, {3'h0, `RFP_WM_RST, 3'h0, `RFP_WM_RST});
        apb(1'b1, `RFP_OFS_WATERMARK, 32'hFFFFFFFF);
        apb(1'b0, `RFP_OFS_WATERMARK, 32'h0);
        chk(rd, 32'h1FFF1FFF);
        apb(1'b1, 12'h054, 32'hFFFFFFFF);
        apb(1'b0, 12'h054, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        $display("test regs done");
    endtask
    // ready gating by count and accept
    task automatic t_thr();
        apb(1'b1, `RFP_OFS_START_RETX, 32'h0003FFFF);
        mark(1'b0);
        words(2);
        tick(6);
        chk(fabric_rx_ready, 1'b0);
        words(1);
        tick(5);
        chk(fabric_rx_ready, 1'b1);
        @(posedge pclk);
        accept_en <= 1'b0;
        tick(5);
        chk(fabric_rx_ready, 1'b0);
        @(posedge pclk);
        accept_en <= 1'b1;
        mark(1'b1);
        $display("test threshold done");
    endtask
    task automatic t_full();
        apb(1'b1, `RFP_OFS_START_RETX, 32'h0FFFFFFF);
        short_frame_drop_setting <= 1'b1;
        mark(1'b0);
        words(20);
        tick(6);
        chk(fabric_rx_ready, 1'b0);
        mark(1'b1);
        tick(5);
        chk(fabric_rx_ready, 1'b1);
        $display("test full frame done");
    endtask
    task automatic t_pause();
        apb(1'b1, `RFP_OFS_WATERMARK, 32'h00080002);
        apb(1'b1, `RFP_OFS_START_RETX, 32'h0FFF0003);
        rx_level <= 13'h0007;
        tick(6);
        chk(tx_ctrl_req, 1'b0);
        @(posedge pclk);
        rx_level <= 13'h0008;
        wait_req(1'b1);
        chk({tx_ctrl_req, tx_pause_val}, {1'b1, `RFP_XOFF_VAL});
        wait_req(1'b0);
        // three quanta of 128 cycles: re-request lands 259 to 386 cycles after the ack
        tick(255);
        chk(tx_ctrl_req, 1'b0);
        for (int n = 0; n < 135 && tx_ctrl_req !== 1'b1; n++) tick(1);
        chk({tx_ctrl_req, tx_pause_val}, {1'b1, `RFP_XOFF_VAL});
        wait_req(1'b0);
        @(posedge pclk);
        rx_level <= 13'h0002;
        wait_req(1'b1);
        chk({tx_ctrl_req, tx_pause_val}, {1'b1, `RFP_XON_VAL});
        wait_req(1'b0);
        chk(tx_ctrl_req, 1'b0);
        $display("test pause done");
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_thr();
        t_full();
        t_pause();
        end_sim();
    end
    // watchdog, several times the expected run
    initial begin
        #60000;
        n_errors++;
        end_sim();
    end
endmodule // tb
